// ### sar_adc_pkg.sv
// constants shared by the converter control logic and its clock divider
// assumes a single clock that stands for the converter oscillator
package sar_adc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] RESULT_IDX = 8'hd0;
    localparam logic [7:0] CONTROL_IDX = 8'hd1;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'hd8;
    localparam logic [7:0] IRQ_MASK_IDX = 8'hd9;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] RESULT_ADDR = {2'h0, RESULT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = {2'h0, CONTROL_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR =
        {2'h0, IRQ_STATUS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};

    // control register fields
    localparam int IRQ_EN_BIT = 7;
    localparam int EOC_BIT = 6;
    localparam int START_BIT = 5;
    localparam int POWER_BIT = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h40;

    // interrupt status / mask layout
    localparam int DONE_EVT_BIT = 0;
    localparam logic [0:0] IRQ_MASK_RESET = 1'h0;

    // converter timing
    localparam int RES_BITS = 8;
    localparam int CLK_DIV = 12;
    localparam int CONV_TIME_NS = 70000;
    localparam int OSC_KHZ = 8000;
    // longest time rounds down: 560 oscillator cycles, 46 divided ticks
    localparam int CONV_TICKS = (CONV_TIME_NS * OSC_KHZ / 1000000) / CLK_DIV;
    localparam int SAMPLE_TICKS = CONV_TICKS - RES_BITS;

endpackage

// ### sar_tick_div.sv
// divide-by-n tick generator for the successive-approximation sequencer
// assumes clk is the oscillator; restart realigns the tick to a start
`timescale 1ns/10ps
module sar_tick_div
    import sar_adc_pkg::*;
#(
    parameter int DIV = CLK_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic restart,
    // one-cycle tick every DIV clocks
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t s_r;
    div_state_t s_nxt;

    initial begin
        if (DIV < 2) begin
            $error("sar_tick_div: DIV must be at least 2");
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (restart) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == LAST) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule

// ### sar_adc_control.sv
// control logic of an 8-bit successive-approximation converter, apb slave
// assumes an external comparator and dac; one clock, synchronous inputs
`timescale 1ns/10ps
module sar_adc_control
    import sar_adc_pkg::*;
#(
    parameter int SAMPLE_LEN = SAMPLE_TICKS,
    parameter int DIV = CLK_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic cmp_in,
    output logic [RES_BITS-1:0] dac_code,
    output logic sample_en,
    output logic adc_power,
    // interrupt, level
    output logic irq
);
    localparam int SW = $clog2(SAMPLE_LEN + 1);
    localparam int BW = $clog2(RES_BITS);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_RESULT,
        SEL_CONTROL,
        SEL_STATUS,
        SEL_MASK
    } reg_sel_t;

    typedef struct packed {
        conv_state_t state;
        logic [SW-1:0] sample_cnt;
        logic [BW-1:0] bit_idx;
        logic [RES_BITS-1:0] trial;
        logic [RES_BITS-1:0] result;
        logic irq_en;
        logic eoc;
        logic power;
        logic done_sts;
        logic done_mask;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t s_r;
    ctl_state_t s_nxt;

    logic tick;
    logic restart;
    logic setup;
    logic access;
    logic wr;
    logic start_req;
    reg_sel_t sel_setup;
    reg_sel_t sel_access;

    initial begin
        if (SAMPLE_LEN < 1) begin
            $error("sar_adc_control: SAMPLE_LEN must be at least 1");
        end
        if (DIV != CLK_DIV) begin
            $error("sar_adc_control: sequencer needs the fixed divider");
        end
    end

    // unmapped addresses and misaligned ones decode to none
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        if (a == RESULT_ADDR) begin
            r = SEL_RESULT;
        end else if (a == CONTROL_ADDR) begin
            r = SEL_CONTROL;
        end else if (a == IRQ_STATUS_ADDR) begin
            r = SEL_STATUS;
        end else if (a == IRQ_MASK_ADDR) begin
            r = SEL_MASK;
        end
        return r;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign sel_setup = decode(paddr);
    assign sel_access = decode(paddr);
    // start is only honoured if the same write sets power; a write that also powers up
    // counts, so software can enable and start in one go
    assign start_req = wr && (sel_access == SEL_CONTROL)
        && pwdata[START_BIT] && pwdata[POWER_BIT];
    // divider realigned on every start so each conversion has equal length
    assign restart = start_req;

    sar_tick_div #(
        .DIV(DIV)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .restart(restart),
        .tick(tick)
    );

    always_comb begin
        s_nxt = s_r;

        // successive approximation sequencer
        case (s_r.state)
            ST_IDLE: begin
                s_nxt.state = ST_IDLE;
            end
            ST_SAMPLE: begin
                if (tick) begin
                    if (s_r.sample_cnt == SW'(1)) begin
                        s_nxt.state = ST_CONVERT;
                        s_nxt.bit_idx = BW'(RES_BITS - 1);
                        s_nxt.trial = RES_BITS'(1) << (RES_BITS - 1);
                    end else begin
                        s_nxt.sample_cnt = s_r.sample_cnt - SW'(1);
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    // comparator low: input below trial, drop the bit
                    if (!cmp_in) begin
                        s_nxt.trial[s_r.bit_idx] = 1'b0;
                    end
                    if (s_r.bit_idx == '0) begin
                        s_nxt.state = ST_IDLE;
                        s_nxt.result = s_nxt.trial;
                        s_nxt.eoc = 1'b1;
                        s_nxt.done_sts = 1'b1;
                    end else begin
                        s_nxt.bit_idx = s_r.bit_idx - BW'(1);
                        s_nxt.trial[s_r.bit_idx - BW'(1)] = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase

        // register writes take effect at the access edge
        if (wr) begin
            if (sel_access == SEL_CONTROL) begin
                s_nxt.irq_en = pwdata[IRQ_EN_BIT];
                s_nxt.power = pwdata[POWER_BIT];
                // eoc and low bits are not writable
                if (!pwdata[POWER_BIT]) begin
                    // power-down idles the converter, result kept
                    s_nxt.state = ST_IDLE;
                    s_nxt.trial = '0;
                end
            end else if (sel_access == SEL_STATUS) begin
                // write one to clear; a same-cycle event wins
                if (pwdata[DONE_EVT_BIT] && !s_nxt.done_sts) begin
                    s_nxt.done_sts = 1'b0;
                end else if (pwdata[DONE_EVT_BIT] && s_nxt.state != ST_IDLE)
                begin
                    s_nxt.done_sts = 1'b0;
                end else if (pwdata[DONE_EVT_BIT] && !s_r.done_sts) begin
                    s_nxt.done_sts = 1'b1;
                end else if (pwdata[DONE_EVT_BIT]
                    && !(s_r.state == ST_CONVERT && tick
                    && s_r.bit_idx == '0)) begin
                    s_nxt.done_sts = 1'b0;
                end
            end else if (sel_access == SEL_MASK) begin
                s_nxt.done_mask = pwdata[DONE_EVT_BIT];
            end
        end

        // a start overrides the state and flags of a conversion finishing in the same cycle; its result is still stored
        if (start_req) begin
            s_nxt.state = ST_SAMPLE;
            s_nxt.sample_cnt = SW'(SAMPLE_LEN);
            s_nxt.trial = '0;
            s_nxt.bit_idx = '0;
            s_nxt.eoc = 1'b0;
            s_nxt.done_sts = s_r.done_sts;
        end

        // read data captured in the setup cycle
        if (setup) begin
            s_nxt.rdata = '0;
            if (sel_setup == SEL_RESULT) begin
                s_nxt.rdata[RES_BITS-1:0] = s_r.result;
            end else if (sel_setup == SEL_CONTROL) begin
                s_nxt.rdata[IRQ_EN_BIT] = s_r.irq_en;
                s_nxt.rdata[EOC_BIT] = s_r.eoc;
                s_nxt.rdata[START_BIT] = 1'b0;
                s_nxt.rdata[POWER_BIT] = s_r.power;
            end else if (sel_setup == SEL_STATUS) begin
                s_nxt.rdata[DONE_EVT_BIT] = s_r.done_sts;
            end else if (sel_setup == SEL_MASK) begin
                s_nxt.rdata[DONE_EVT_BIT] = s_r.done_mask;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // reset aborts any conversion
            s_r.state <= ST_IDLE;
            s_r.sample_cnt <= '0;
            s_r.bit_idx <= '0;
            s_r.trial <= '0;
            s_r.result <= '0;
            s_r.irq_en <= CONTROL_RESET[IRQ_EN_BIT];
            s_r.eoc <= CONTROL_RESET[EOC_BIT];
            s_r.power <= CONTROL_RESET[POWER_BIT];
            s_r.done_sts <= 1'b0;
            s_r.done_mask <= IRQ_MASK_RESET;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // zero wait state: access phase always completes at once
    assign pready = access;
    assign pslverr = access && (sel_access == SEL_NONE);
    assign prdata = s_r.rdata;

    assign dac_code = s_r.trial;
    assign sample_en = (s_r.state == ST_SAMPLE);
    assign adc_power = s_r.power;

    // level request doubles as the wake-up source in processor wait
    assign irq = s_r.irq_en && s_r.done_sts && s_r.done_mask;
endmodule

// ### sar_analog_src.sv
// comparator model of one analog source on the selected input
// assumes the bench holds level steady through a conversion
`timescale 1ns/10ps
module sar_analog_src (
    // trial code in, input level
    input wire logic [7:0] dac_code,
    input wire logic [7:0] level,
    // comparator answer
    output logic cmp_in
);
    // one source only, so never two lines selected at once
    assign cmp_in = level >= dac_code;
endmodule

// ### sar_adc_monitor.sv
// port checker for the converter control block
// assumes bind onto sar_adc_control, one clock domain
`timescale 1ns/10ps
module sar_adc_monitor
    import sar_adc_pkg::*;
#(
    parameter int SAMPLE_LEN = SAMPLE_TICKS,
    parameter int DIV = CLK_DIV
) (
    // clock, reset, apb
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter side
    input wire logic cmp_in,
    input wire logic [RES_BITS-1:0] dac_code,
    input wire logic sample_en,
    input wire logic adc_power,
    input wire logic irq
);
    localparam int CONV = (SAMPLE_LEN + RES_BITS) * DIV;
    localparam int SAMP = SAMPLE_LEN * DIV;
    logic acc, cwr, go, en_r, mk_r, run_r;
    int cnt_r;
    assign acc = psel && penable;
    assign cwr = acc && pwrite && paddr == CONTROL_ADDR;
    assign go = cwr && pwdata[START_BIT] && pwdata[POWER_BIT];
    // shadow of enable and mask, so irq can be tied to its cause
    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_r <= 1'b0;
            mk_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            if (cwr) en_r <= pwdata[IRQ_EN_BIT];
            if (acc && pwrite && paddr == IRQ_MASK_ADDR) mk_r <= pwdata[0];
            // no port shows the end of the bit trials, so track a window
            if (go) begin
                run_r <= 1'b1;
            end else if (cwr && !pwdata[POWER_BIT]) begin
                run_r <= 1'b0;
            end else if (cnt_r == CONV + 2) begin
                run_r <= 1'b0;
            end
        end
        cnt_r <= go ? 0 : cnt_r + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_RST_QUIET: assert property (disable iff (1'b0)
        !rstn |=> !irq && !sample_en && !adc_power)
        else $error("outputs active after reset");
    AST_START: assert property (go |=> sample_en && dac_code == 8'h0)
        else $error("start write did not begin sampling");
    AST_ONE_SHOT: assert property ($rose(sample_en) |-> $past(go))
        else $error("conversion began without a start write");
    AST_SAMPLE_LEN: assert property ($fell(sample_en) && adc_power
        |-> cnt_r >= SAMP && cnt_r <= SAMP + 2)
        else $error("sample phase length wrong");
    AST_CONV_LEN: assert property ($rose(irq) && $stable(en_r)
        && $stable(mk_r) |-> cnt_r >= CONV && cnt_r <= CONV + 2)
        else $error("conversion length wrong");
    AST_POWER: assert property (cwr |=> adc_power == $past(pwdata[4]))
        else $error("power select not taken");
    AST_PDOWN: assert property (!adc_power |-> !sample_en)
        else $error("converting while powered down");
    AST_IRQ_SET: assert property (run_r && cnt_r == CONV + 2
        && en_r && mk_r |-> irq)
        else $error("no interrupt at end of conversion");
    AST_IRQ_EN: assert property (irq |-> en_r && mk_r)
        else $error("interrupt while disabled");
    AST_RD_ZERO: assert property (acc && !pwrite &&
        paddr == CONTROL_ADDR |-> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
        else $error("control reads nonzero in unused bits");
    cover property (go);
    cover property (go && sample_en);
    cover property ($rose(irq));
endmodule
bind sar_adc_control sar_adc_monitor #(.SAMPLE_LEN(SAMPLE_LEN), .DIV(DIV))
    mon (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmp_in, .dac_code, .sample_en, .adc_power, .irq);

// ### sar_adc_control_bench.sv
// self-checking bench for the converter control block
// assumes the analog source model and the bound checker beside it
`timescale 1ns/10ps
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
end
module sar_adc_control_bench
    import sar_adc_pkg::*;
;
    // short sample phase keeps the run brief
    localparam int SL = 2;
    localparam int CONV = (SL + RES_BITS) * CLK_DIV;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, cmp_in, err;
    logic sample_en, adc_power, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] dac_code, level;
    int miscompares = 0, tests_run = 0, seed = 32'hcb9c;
    int n, lv, m_ctl, m_sts, m_msk, m_res;
    sar_adc_control #(.SAMPLE_LEN(SL)) dut (.clk, .rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_in,
        .dac_code, .sample_en, .adc_power, .irq);
    sar_analog_src src (.dac_code, .level, .cmp_in);
    function automatic int sar(input int v);
        int r = 0;
        for (int b = 7; b >= 0; b--) begin
            if (v >= (r | (1 << b))) r = r | (1 << b);
        end
        return r;
    endfunction
    task automatic apb(input bit w, input logic [ADDR_W-1:0] a, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next setup is a fresh assignment
        @(posedge clk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        if (a == CONTROL_ADDR)
            m_ctl = (d & 8'h90) | ((d & 8'h30) == 8'h30 ? 0 : m_ctl & 8'h40);
        if (a == IRQ_STATUS_ADDR && d[0]) m_sts = 0;
        if (a == IRQ_MASK_ADDR) m_msk = d & 1;
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input int e);
        apb(1'b0, a, 0);
        `CHK(q, e)
    endtask
    task automatic conv(input int d);
        lv = $random(seed) & 255;
        level <= lv[7:0];
        wr(CONTROL_ADDR, d);
        n = 0;
        // sample_en covers only the sample phase, bit trials follow
        do begin
            @(posedge clk);
            n++;
        end while (sample_en !== 1'b0 && n < 5000);
        `CHK(n >= SL * CLK_DIV && n <= SL * CLK_DIV + 2, 1'b1)
        // setup lands just before the result is due: flag still low
        repeat (CONV - n - 2) @(posedge clk);
        rd(CONTROL_ADDR, m_ctl);
        m_ctl = m_ctl | 8'h40;
        m_sts = 1;
        m_res = sar(lv);
        rd(CONTROL_ADDR, m_ctl);
        `CHK(irq, 1'(m_ctl[7] & m_sts[0] & m_msk[0]))
        rd(RESULT_ADDR, m_res);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, level} <= '0;
        m_ctl = 8'h40;
        m_sts = 0;
        m_msk = 0;
        m_res = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(CONTROL_ADDR, m_ctl);
        rd(RESULT_ADDR, 0);
        rd(IRQ_MASK_ADDR, 0);
        rd(12'h100, 0);
        `CHK(err, 1'b1)
        wr(CONTROL_ADDR, 32'h1f);
        rd(CONTROL_ADDR, m_ctl);
        wr(IRQ_MASK_ADDR, 1);
        conv(32'hb0);
        wr(IRQ_STATUS_ADDR, 1);
        `CHK(irq, 1'b0)
        wr(RESULT_ADDR, 32'h5a);
        rd(RESULT_ADDR, m_res);
        repeat (2 * CONV) @(posedge clk);
        `CHK(sample_en, 1'b0)
        wr(IRQ_MASK_ADDR, 0);
        conv(32'hb0);
        wr(IRQ_MASK_ADDR, 1);
        `CHK(irq, 1'b1)
        wr(CONTROL_ADDR, 32'h10);
        `CHK(irq, 1'b0)
        wr(CONTROL_ADDR, 32'h30);
        repeat (40) @(posedge clk);
        rd(CONTROL_ADDR, m_ctl);
        conv(32'h30);
        wr(CONTROL_ADDR, 32'h30);
        wr(CONTROL_ADDR, 32'h00);
        `CHK(sample_en, 1'b0)
        `CHK(adc_power, 1'b0)
        wr(CONTROL_ADDR, 32'h20);
        repeat (CONV) @(posedge clk);
        rd(CONTROL_ADDR, m_ctl);
        for (int i = 0; i < 4; i++) begin
            wr(CONTROL_ADDR, 32'h10);
            conv(32'h30 | ($random(seed) & 32'h80));
        end
        wr(CONTROL_ADDR, 32'hb0);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        m_ctl = 8'h40;
        m_msk = 0;
        @(posedge clk);
        rd(CONTROL_ADDR, m_ctl);
        rd(IRQ_MASK_ADDR, m_msk);
        `CHK(sample_en, 1'b0)
        end_of_test();
    end
endmodule
